// [hw/fsu_top.sv]
// Frequency-setting update: user register, PLL register and triggers.
// Assumes power-on reset on rstn and a free-running link sampling clock.
// Notes on behaviour
// - Feedback divider is 6-bit integer plus 24-bit fraction over two to the 24th.
// - Synthesiser runs at reference times divider; output divides that by ratio.
// - Four-bit output code selects ratios 4 through 56 per table.
// - User register holds code, integer and fraction; host may rewrite anytime.
// - Synthesiser uses only the PLL register; user writes alone change nothing.
// - Power-on loads defaults into user register, then into PLL register.
// - Writing 1 to either trigger while idle copies user integer and fraction into PLL register; the full trigger also copies the code.
// - Full retune recalibrates, stops output briefly, restarts after calibration.
// - Power cycle discards reprogrammed settings and restores factory default.
// - Small step moves only integer and fraction, no calibration, no interruption.
// - Each full retune records the new centre for later small steps.
// - Serial engine restarts on any start or repeated start.
`timescale 1ns/10ps
module fsu_top
#(
    parameter int CAL_CYCLES = fsu_pkg::CAL_CYCLES
)
(
    // System clock and power-on reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Serial link
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Synthesiser settings
    output logic [3:0] pll_output_divider_code,
    output logic [5:0] pll_feedback_integer,
    output logic [23:0] pll_feedback_fraction,
    output logic [5:0] pll_output_ratio,
    output logic pll_calibrate,
    output logic clock_out_enable,
    // Centre of the small-step window
    output logic [5:0] centre_feedback_integer,
    output logic [23:0] centre_feedback_fraction
);
    // Elaboration-time check of the calibration length
    if (CAL_CYCLES < 1)
    begin : g_bad_cal
        $error("CAL_CYCLES must be at least one");
    end


    localparam int CW = $clog2(CAL_CYCLES + 1);

    // Link side
    logic wr_stb;
    logic [7:0] wr_addr, wr_data, rd_addr;
    logic [7:0] rd_data;
    logic tgl_link;
    logic [7:0] hold_addr, hold_data;
    fsu_i2c u_i2c
    (
        .link_clk(link_clk),
        .rstn(rstn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );
    // Writes cross as held words plus a toggle; a byte takes nine serial clocks, far above the sync delay
    always_ff @(posedge link_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tgl_link <= 1'b0;
            hold_addr <= 8'h00;
            hold_data <= 8'h00;
        end
        else if (wr_stb)
        begin
            tgl_link <= !tgl_link;
            hold_addr <= wr_addr;
            hold_data <= wr_data;
        end
    end

    // User register
    logic [3:0] usr_code, next_usr_code;
    logic [5:0] usr_int, next_usr_int;
    logic [23:0] usr_frac, next_usr_frac;
    logic [2:0] tgl_sync;
    logic wr_evt;
    assign wr_evt = tgl_sync[2] ^ tgl_sync[1];
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tgl_sync <= 3'h0;
        end
        else
        begin
            tgl_sync <= {tgl_sync[1:0], tgl_link};
        end
    end

    // Read data: user register mirrored back into the link domain through a two-stage sync
    logic [37:0] mirror, mir_s1, mir_s2;
    assign mirror = {usr_code, usr_int, usr_frac, 4'h0};
    always_ff @(posedge link_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mir_s1 <= 38'h0;
            mir_s2 <= 38'h0;
        end
        else
        begin
            mir_s1 <= mirror;
            mir_s2 <= mir_s1;
        end
    end
    // Values only change while the host is idle, so word tearing is not expected
    always_comb
    begin
        case (rd_addr)
            fsu_pkg::ADDR_CODE: rd_data = {4'h0, mir_s2[37:34]};
            fsu_pkg::ADDR_INT: rd_data = {2'h0, mir_s2[33:28]};
            fsu_pkg::ADDR_FRAC_H: rd_data = mir_s2[27:20];
            fsu_pkg::ADDR_FRAC_M: rd_data = mir_s2[19:12];
            fsu_pkg::ADDR_FRAC_L: rd_data = mir_s2[11:4];
            default: rd_data = 8'h00;
        endcase
    end

    // Update sequencer
    fsu_pkg::fsu_state_e st, next_st;
    logic [CW-1:0] cal_cnt, next_cal_cnt;
    logic [3:0] p_code, next_p_code;
    logic [5:0] p_int, next_p_int, c_int, next_c_int;
    logic [23:0] p_frac, next_p_frac, c_frac, next_c_frac;
    logic trig_new, trig_sml, is_ctrl;
    assign is_ctrl = wr_evt && (hold_addr == fsu_pkg::ADDR_CTRL0 || hold_addr == fsu_pkg::ADDR_CTRL1);
    assign trig_new = is_ctrl && hold_data[fsu_pkg::CTRL_NEW_BIT];
    assign trig_sml = is_ctrl && hold_data[fsu_pkg::CTRL_SML_BIT];

    always_comb
    begin
        next_usr_code = usr_code;
        next_usr_int = usr_int;
        next_usr_frac = usr_frac;
        next_st = st;
        next_cal_cnt = cal_cnt;
        next_p_code = p_code;
        next_p_int = p_int;
        next_p_frac = p_frac;
        next_c_int = c_int;
        next_c_frac = c_frac;
        if (wr_evt)
        begin
            // User writes touch only the user register
            case (hold_addr)
                fsu_pkg::ADDR_CODE: next_usr_code = hold_data[3:0];
                fsu_pkg::ADDR_INT: next_usr_int = hold_data[5:0];
                fsu_pkg::ADDR_FRAC_H: next_usr_frac[23:16] = hold_data;
                fsu_pkg::ADDR_FRAC_M: next_usr_frac[15:8] = hold_data;
                fsu_pkg::ADDR_FRAC_L: next_usr_frac[7:0] = hold_data;
                default: next_usr_frac = usr_frac;
            endcase
        end
        case (st)
            fsu_pkg::FSU_LOAD:
            begin
                // Power-on copy of defaults into the PLL register
                next_p_code = usr_code;
                next_p_int = usr_int;
                next_p_frac = usr_frac;
                next_c_int = usr_int;
                next_c_frac = usr_frac;
                next_cal_cnt = CW'(CAL_CYCLES);
                next_st = fsu_pkg::FSU_CAL;
            end
            fsu_pkg::FSU_CAL:
            begin
                // Output held off until calibration time runs out
                if (cal_cnt <= CW'(1))
                begin
                    next_cal_cnt = '0;
                    next_st = fsu_pkg::FSU_IDLE;
                end
                else
                begin
                    next_cal_cnt = cal_cnt - CW'(1);
                end
            end
            fsu_pkg::FSU_IDLE:
            begin
                if (trig_new)
                begin
                    // Full copy and new centre
                    next_p_code = usr_code;
                    next_p_int = usr_int;
                    next_p_frac = usr_frac;
                    next_c_int = usr_int;
                    next_c_frac = usr_frac;
                    next_cal_cnt = CW'(CAL_CYCLES);
                    next_st = fsu_pkg::FSU_CAL;
                end
                else if (trig_sml)
                begin
                    // Only the feedback divider moves, output keeps running
                    next_p_int = usr_int;
                    next_p_frac = usr_frac;
                end
            end
            default: next_st = fsu_pkg::FSU_IDLE;
        endcase
    end

    // Reset restores the factory defaults, discarding any reprogramming
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            usr_code <= fsu_pkg::NVM_CODE;
            usr_int <= fsu_pkg::NVM_INT;
            usr_frac <= fsu_pkg::NVM_FRAC;
            st <= fsu_pkg::FSU_LOAD;
            cal_cnt <= '0;
            p_code <= 4'h0;
            p_int <= 6'h00;
            p_frac <= 24'h000000;
            c_int <= 6'h00;
            c_frac <= 24'h000000;
        end
        else
        begin
            usr_code <= next_usr_code;
            usr_int <= next_usr_int;
            usr_frac <= next_usr_frac;
            st <= next_st;
            cal_cnt <= next_cal_cnt;
            p_code <= next_p_code;
            p_int <= next_p_int;
            p_frac <= next_p_frac;
            c_int <= next_c_int;
            c_frac <= next_c_frac;
        end
    end

    // Divider fields drive the synthesiser as integer plus fraction over 2^24
    fsu_ratio u_ratio
    (
        .code(p_code),
        .ratio(pll_output_ratio)
    );
    assign pll_output_divider_code = p_code;
    assign pll_feedback_integer = p_int;
    assign pll_feedback_fraction = p_frac;
    assign pll_calibrate = (st != fsu_pkg::FSU_IDLE);
    assign clock_out_enable = (st == fsu_pkg::FSU_IDLE);
    assign centre_feedback_integer = c_int;
    assign centre_feedback_fraction = c_frac;
endmodule : fsu_top

// [include/fsu_pkg.sv]
// Shared constants for the frequency-setting update block.
// Assumes a 100 MHz system clock and a separate serial link clock domain.
package fsu_pkg;
    // Field widths
    localparam int CODE_W = 4;
    localparam int INT_W = 6;
    localparam int FRAC_W = 24;
    localparam int RATIO_W = 6;
    // Register addresses on the serial link
    localparam logic [7:0] ADDR_CODE = 8'h10;
    localparam logic [7:0] ADDR_INT = 8'h11;
    localparam logic [7:0] ADDR_FRAC_H = 8'h12;
    localparam logic [7:0] ADDR_FRAC_M = 8'h13;
    localparam logic [7:0] ADDR_FRAC_L = 8'h14;
    localparam logic [7:0] ADDR_CTRL0 = 8'h15;
    localparam logic [7:0] ADDR_CTRL1 = 8'h50;
    // Control register bit positions
    localparam int CTRL_NEW_BIT = 2;
    localparam int CTRL_SML_BIT = 1;
    // Default slave address and non-volatile defaults (plain defaults)
    localparam logic [6:0] SLAVE_ADDR = 7'h37;
    localparam logic [CODE_W-1:0] NVM_CODE = 4'h9;
    localparam logic [INT_W-1:0] NVM_INT = 6'h18;
    localparam logic [FRAC_W-1:0] NVM_FRAC = 24'h60a9dc;
    // Recalibration time: 1.5 ms, in microseconds, at 100 MHz
    localparam int CAL_TIME_US = 1500;
    localparam int CLK_MHZ = 100;
    localparam int CAL_CYCLES = CAL_TIME_US * CLK_MHZ;
    // Mode of update
    typedef enum logic [1:0] {FSU_IDLE, FSU_LOAD, FSU_CAL} fsu_state_e;
endpackage : fsu_pkg

// [hw/fsu_ratio.sv]
// Output divider code to ratio lookup.
// Assumes the code comes from registered PLL settings.
`timescale 1ns/10ps
module fsu_ratio
(
    // Code in
    input wire logic [3:0] code,
    // Ratio out
    output logic [5:0] ratio
);
    always_comb
    begin
        case (code)
            4'h0: ratio = 6'h04;
            4'h1: ratio = 6'h05;
            4'h2: ratio = 6'h06;
            4'h3: ratio = 6'h07;
            4'h4: ratio = 6'h08;
            4'h5: ratio = 6'h0a;
            4'h6: ratio = 6'h0c;
            4'h7: ratio = 6'h0e;
            4'h8: ratio = 6'h10;
            4'h9: ratio = 6'h14;
            4'ha: ratio = 6'h18;
            4'hb: ratio = 6'h1c;
            4'hc: ratio = 6'h20;
            4'hd: ratio = 6'h28;
            4'he: ratio = 6'h30;
            default: ratio = 6'h38;
        endcase
    end
endmodule : fsu_ratio

// [hw/fsu_i2c.sv]
// Serial slave for the register map, clocked by its own sampling clock.
// Assumes scl and sda arrive asynchronously and are synchronised here.
`timescale 1ns/10ps
module fsu_i2c
(
    // Clock and reset of the link domain
    input wire logic link_clk,
    input wire logic rstn,
    // Pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Register write strobe and read data, link domain
    output logic wr_stb,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    typedef enum logic [2:0] {SI_IDLE, SI_DEV, SI_REG, SI_WDAT, SI_RDAT, SI_ACK, SI_SKIP} si_state_e;
    logic [1:0] scl_s, sda_s;
    logic scl_d, sda_d;
    si_state_e st, next_st, after;
    si_state_e next_after;
    logic [3:0] bitc, next_bitc;
    logic [7:0] sh, next_sh, ptr, next_ptr, tx, next_tx;
    logic drive, next_drive, stb, next_stb;
    logic start_c, stop_c, rise, fall;
    always_ff @(posedge link_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_s <= {scl_s[0], scl_in};
            sda_s <= {sda_s[0], sda_in};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end
    assign start_c = scl_s[1] && scl_d && sda_d && !sda_s[1];
    assign stop_c = scl_s[1] && scl_d && !sda_d && sda_s[1];
    assign rise = scl_s[1] && !scl_d;
    assign fall = !scl_s[1] && scl_d;
    always_comb
    begin
        next_st = st;
        next_after = after;
        next_bitc = bitc;
        next_sh = sh;
        next_ptr = ptr;
        next_tx = tx;
        next_drive = drive;
        next_stb = 1'b0;
        if (start_c)
        begin
            // Any start, even out of sequence, restarts the engine
            next_st = SI_DEV;
            next_bitc = 4'h0;
            next_drive = 1'b0;
        end
        else if (stop_c)
        begin
            next_st = SI_IDLE;
            next_drive = 1'b0;
        end
        else if (st == SI_ACK)
        begin
            if (fall)
            begin
                next_drive = 1'b0;
                next_bitc = 4'h0;
                next_st = after;
                if (after == SI_RDAT)
                begin
                    next_tx = rd_data;
                    next_drive = !rd_data[7];
                end
            end
        end
        else if (st != SI_IDLE && st != SI_SKIP)
        begin
            if (rise)
            begin
                next_sh = {sh[6:0], sda_s[1]};
                next_bitc = bitc + 4'h1;
            end
            if (fall && st == SI_RDAT)
            begin
                if (bitc == 4'h8)
                begin
                    next_drive = 1'b0;
                    next_ptr = ptr + 8'h01;
                    // Master acks on the ninth clock; a nack ends the read
                    next_st = SI_ACK;
                    next_after = SI_RDAT;
                end
                else
                begin
                    next_tx = {tx[6:0], 1'b0};
                    next_drive = !tx[6];
                end
            end
            else if (fall && bitc == 4'h8)
            begin
                next_drive = 1'b1;
                next_st = SI_ACK;
                case (st)
                    SI_DEV:
                    begin
                        if (sh[7:1] != fsu_pkg::SLAVE_ADDR)
                        begin
                            next_drive = 1'b0;
                            next_st = SI_SKIP;
                        end
                        next_after = sh[0] ? SI_RDAT : SI_REG;
                        if (sh[0])
                        begin
                            next_ptr = ptr;
                        end
                    end
                    SI_REG:
                    begin
                        next_ptr = sh;
                        next_after = SI_WDAT;
                    end
                    default:
                    begin
                        next_stb = 1'b1;
                        next_after = SI_WDAT;
                    end
                endcase
            end
        end
        if (st == SI_ACK && after == SI_RDAT && rise && sda_s[1])
        begin
            next_st = SI_SKIP;
        end
    end
    always_ff @(posedge link_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= SI_IDLE;
            after <= SI_IDLE;
            bitc <= 4'h0;
            sh <= 8'h00;
            ptr <= 8'h00;
            tx <= 8'h00;
            drive <= 1'b0;
            stb <= 1'b0;
        end
        else
        begin
            st <= next_st;
            after <= next_after;
            bitc <= next_bitc;
            sh <= next_sh;
            // Write pointer advances after each stored byte
            ptr <= stb ? ptr + 8'h01 : next_ptr;
            tx <= next_tx;
            drive <= next_drive;
            stb <= next_stb;
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe = drive;
    assign wr_stb = stb;
    assign wr_addr = ptr;
    assign wr_data = sh;
    assign rd_addr = ptr;
endmodule : fsu_i2c

// [tb/fsu_top_monitor.sv]
// Port checker for the frequency-setting update block.
// Assumes it is bound into fsu_top and sees only its ports.
`timescale 1ns/10ps
module fsu_top_monitor
#(
    parameter int CAL_CYCLES = 20
)
(
    // Clock, reset and synthesiser side
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [3:0] pll_output_divider_code,
    input wire logic [5:0] pll_feedback_integer,
    input wire logic [23:0] pll_feedback_fraction,
    input wire logic [5:0] pll_output_ratio,
    input wire logic pll_calibrate,
    input wire logic clock_out_enable,
    input wire logic [5:0] centre_feedback_integer,
    input wire logic [23:0] centre_feedback_fraction
);
    localparam logic [5:0] RATIO [16] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0a, 6'h0c, 6'h0e,
        6'h10, 6'h14, 6'h18, 6'h1c, 6'h20, 6'h28, 6'h30, 6'h38};
    logic [31:0] cal_cnt;
    logic [31:0] next_cal_cnt;

    always_comb
    begin
        next_cal_cnt = pll_calibrate ? cal_cnt + 32'h1 : 32'h0;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            cal_cnt <= 32'h0;
        else
            cal_cnt <= next_cal_cnt;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    enable_inverse_a: assert property (clock_out_enable == !pll_calibrate)
        else $error("enable is not the inverse of calibrate");
    cal_length_a: assert property ($fell(pll_calibrate) |-> cal_cnt >= CAL_CYCLES)
        else $error("calibration ended early");
    cal_bound_a: assert property (cal_cnt <= CAL_CYCLES + 2)
        else $error("calibration ran too long");
    cal_hold_a: assert property (pll_calibrate && $past(pll_calibrate) && $past(pll_calibrate, 2)
        && $past(rstn, 3) |-> $stable(pll_feedback_integer) && $stable(pll_feedback_fraction)
        && $stable(pll_output_divider_code))
        else $error("settings moved during calibration");
    ratio_map_a: assert property (pll_output_ratio == RATIO[pll_output_divider_code])
        else $error("ratio does not match code");
    code_full_only_a: assert property ($changed(pll_output_divider_code) |-> pll_calibrate)
        else $error("code changed without calibration");
    small_glitchless_a: assert property (($changed(pll_feedback_integer) || $changed(pll_feedback_fraction))
        && !pll_calibrate && !$past(pll_calibrate) |-> clock_out_enable [*4])
        else $error("small step interrupted the output");
    centre_full_only_a: assert property ($changed(centre_feedback_integer) || $changed(centre_feedback_fraction)
        |-> pll_calibrate)
        else $error("centre moved outside a full retune");
    centre_match_a: assert property ($fell(pll_calibrate) |-> centre_feedback_integer == pll_feedback_integer
        && centre_feedback_fraction == pll_feedback_fraction)
        else $error("centre differs from retuned setting");
    reset_default_a: assert property (!$past(rstn, 2) && $past(rstn) |-> pll_calibrate
        && pll_output_divider_code == fsu_pkg::NVM_CODE && pll_feedback_integer == fsu_pkg::NVM_INT
        && pll_feedback_fraction == fsu_pkg::NVM_FRAC)
        else $error("defaults not loaded after reset");

    full_cover_c: cover property ($rose(pll_calibrate));
    small_cover_c: cover property ($changed(pll_feedback_fraction) && !pll_calibrate);
    centre_cover_c: cover property ($changed(centre_feedback_fraction));
endmodule : fsu_top_monitor

bind fsu_top fsu_top_monitor #(.CAL_CYCLES(CAL_CYCLES)) mon (
    .ref_clk(ref_clk), .rstn(rstn),
    .pll_output_divider_code(pll_output_divider_code), .pll_feedback_integer(pll_feedback_integer),
    .pll_feedback_fraction(pll_feedback_fraction), .pll_output_ratio(pll_output_ratio),
    .pll_calibrate(pll_calibrate), .clock_out_enable(clock_out_enable),
    .centre_feedback_integer(centre_feedback_integer), .centre_feedback_fraction(centre_feedback_fraction)
);

// [tb/fsu_i2c_host.sv]
// Behavioural serial-bus master for the block's link pins.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/10ps
module fsu_i2c_host
#(
    parameter int QTR = 80
)
(
    // Bus lines; the clock stands high between frames
    output logic scl,
    output logic sda_drv,
    input wire logic sda_line
);
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Serves as a repeated start when the clock is low
    task automatic start_cond();
        #QTR sda_drv = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b0;
        #QTR scl = 1'b0;
    endtask : start_cond

    task automatic clock_bit(input logic b);
        #QTR sda_drv = b;
        #QTR scl = 1'b1;
        #(2 * QTR) scl = 1'b0;
    endtask : clock_bit

    task automatic send_byte(input logic [7:0] b, output logic nak);
        for (int i = 7; i >= 0; i--)
            clock_bit(b[i]);
        #QTR sda_drv = 1'b1;
        #QTR scl = 1'b1;
        #QTR nak = sda_line;
        #QTR scl = 1'b0;
    endtask : send_byte

    task automatic stop_cond();
        #QTR sda_drv = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b1;
        #(4 * QTR);
    endtask : stop_cond

    // An unknown acknowledge counts as missing
    task automatic write_frame(input logic [7:0] sla, input logic [7:0] data [$], output int naks);
        logic nak;
        start_cond();
        send_byte(sla, nak);
        naks = (nak !== 1'b0);
        foreach (data[i])
        begin
            send_byte(data[i], nak);
            naks += (nak !== 1'b0);
        end
        stop_cond();
    endtask : write_frame

    task automatic stray_bits();
        start_cond();
        for (int i = 0; i < 3; i++)
            clock_bit(1'b1);
    endtask : stray_bits
endmodule : fsu_i2c_host

// [tb/test_frequency_setting_update.sv]
// Self-checking bench for fsu_top driven by a behavioural bus master.
// Assumes the port checker is bound to fsu_top from its own file.
`timescale 1ns/10ps
module test_frequency_setting_update;
    localparam int CAL = 200;
    localparam logic [7:0] SLA = {fsu_pkg::SLAVE_ADDR, 1'b0};
    typedef struct packed {
        logic [3:0] code;
        logic [5:0] ratio;
        logic [5:0] fb_int;
        logic [23:0] frac;
    } fsu_row_s;
    // Synthesiser kept in range, low fraction nibble held fixed
    fsu_row_s rows [16] = '{'{4'h0, 6'h04, 6'h17, 24'h00000c}, '{4'h1, 6'h05, 6'h18, 24'h10203c},
        '{4'h2, 6'h06, 6'h19, 24'h7fffec}, '{4'h3, 6'h07, 6'h1a, 24'hfffffc}, '{4'h4, 6'h08, 6'h1b, 24'h55555c},
        '{4'h5, 6'h0a, 6'h17, 24'haaaaac}, '{4'h6, 6'h0c, 6'h18, 24'h3b2f2c}, '{4'h7, 6'h0e, 6'h19, 24'h60a9dc},
        '{4'h8, 6'h10, 6'h1a, 24'h01234c}, '{4'h9, 6'h14, 6'h1b, 24'hedcbac}, '{4'ha, 6'h18, 6'h17, 24'h80000c},
        '{4'hb, 6'h1c, 6'h18, 24'h0f0f0c}, '{4'hc, 6'h20, 6'h19, 24'hf0f0fc}, '{4'hd, 6'h28, 6'h1a, 24'h33333c},
        '{4'he, 6'h30, 6'h1b, 24'h00000c}, '{4'hf, 6'h38, 6'h17, 24'hcccccc}};
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rstn = 1'b0;
    logic scl;
    logic sda_drv;
    wire sda_line;
    logic sda_out;
    logic sda_oe;
    logic [3:0] pll_output_divider_code;
    logic [5:0] pll_feedback_integer;
    logic [23:0] pll_feedback_fraction;
    logic [5:0] pll_output_ratio;
    logic pll_calibrate;
    logic clock_out_enable;
    logic [5:0] centre_feedback_integer;
    logic [23:0] centre_feedback_fraction;
    logic [3:0] exp_code;
    logic [5:0] exp_ratio;
    logic [5:0] exp_int;
    logic [23:0] exp_frac;
    logic [5:0] cen_int;
    logic [23:0] cen_frac;
    logic [7:0] q [$];
    int n_fail = 0;
    int n_checks = 0;
    int naks;

    // Open drain with a pull-up: the line is low if either side pulls it
    assign sda_line = (sda_oe ? sda_out : 1'b1) & sda_drv;
    always #5 ref_clk = ~ref_clk;
    initial
    begin
        #3;
        forever #16 link_clk = ~link_clk;
    end

    fsu_top #(.CAL_CYCLES(CAL)) uut (
        .ref_clk(ref_clk), .rstn(rstn), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .pll_output_divider_code(pll_output_divider_code),
        .pll_feedback_integer(pll_feedback_integer), .pll_feedback_fraction(pll_feedback_fraction),
        .pll_output_ratio(pll_output_ratio), .pll_calibrate(pll_calibrate), .clock_out_enable(clock_out_enable),
        .centre_feedback_integer(centre_feedback_integer), .centre_feedback_fraction(centre_feedback_fraction)
    );
    fsu_i2c_host #(.QTR(80)) host (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    task automatic check_pll();
        chk(pll_output_divider_code, exp_code);
        chk(pll_feedback_integer, exp_int);
        chk(pll_feedback_fraction, exp_frac);
        chk(pll_output_ratio, exp_ratio);
        chk(centre_feedback_integer, cen_int);
        chk(centre_feedback_fraction, cen_frac);
    endtask : check_pll

    // Bounded wait; the exact window length is left to the checker
    task automatic wait_enable();
        for (int k = 0; k < CAL + 50 && clock_out_enable !== 1'b1; k++)
            @(negedge ref_clk);
        chk(clock_out_enable, 1'b1);
    endtask : wait_enable

    task automatic reset_check();
        @(negedge ref_clk);
        rstn = 1'b0;
        repeat (12) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (2) @(negedge ref_clk);
        exp_code = fsu_pkg::NVM_CODE;
        exp_ratio = 6'h14;
        exp_int = fsu_pkg::NVM_INT;
        exp_frac = fsu_pkg::NVM_FRAC;
        cen_int = exp_int;
        cen_frac = exp_frac;
        check_pll();
        chk(pll_calibrate, 1'b1);
        wait_enable();
        $display("test reset done");
    endtask : reset_check

    initial
    begin
        reset_check();
        for (int i = 0; i < 16; i++)
        begin
            q = '{fsu_pkg::ADDR_CODE, {4'h0, rows[i].code}, {2'b00, rows[i].fb_int},
                rows[i].frac[23:16], rows[i].frac[15:8], rows[i].frac[7:0]};
            host.write_frame(SLA, q, naks);
            chk(naks, 0);
            check_pll();
            q = '{(i % 2) ? fsu_pkg::ADDR_CTRL1 : fsu_pkg::ADDR_CTRL0, (i % 3 == 1) ? 8'h06 : 8'h04};
            host.write_frame(SLA, q, naks);
            chk(pll_calibrate, 1'b1);
            wait_enable();
            {exp_code, exp_ratio, exp_int, exp_frac} = rows[i];
            cen_int = exp_int;
            cen_frac = exp_frac;
            check_pll();
            $display("test row %0d done", i);
        end
        q = '{fsu_pkg::ADDR_CODE, 8'h03, 8'h19, 8'h12, 8'h34, 8'h5c};
        host.write_frame(SLA, q, naks);
        q = '{fsu_pkg::ADDR_CTRL0, 8'h02};
        host.write_frame(SLA, q, naks);
        chk(clock_out_enable, 1'b1);
        exp_int = 6'h19;
        exp_frac = 24'h12345c;
        check_pll();
        $display("test small step done");
        // A foreign address must leave the user register alone
        q = '{fsu_pkg::ADDR_INT, 8'h1a};
        host.write_frame(8'h70, q, naks);
        chk(naks, 3);
        host.stray_bits();
        q = '{fsu_pkg::ADDR_CTRL1, 8'h04};
        host.write_frame(SLA, q, naks);
        chk(naks, 0);
        wait_enable();
        exp_code = 4'h3;
        exp_ratio = 6'h07;
        cen_int = exp_int;
        cen_frac = exp_frac;
        check_pll();
        $display("test restart done");
        reset_check();
        end_of_test();
    end

    // The run needs about 57000 cycles; this leaves over half as much again
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        n_fail++;
        end_of_test();
    end
endmodule : test_frequency_setting_update
